// File: src/spt_pkg.sv
// shared constants and types of the soak program timer
package spt_pkg;

   // register byte offsets
   localparam logic [7:0] SPT_OFF_CTRL   = 8'h00;
   localparam logic [7:0] SPT_OFF_SOAK   = 8'h04;
   localparam logic [7:0] SPT_OFF_BAND   = 8'h08;
   localparam logic [7:0] SPT_OFF_STATUS = 8'h0c;
   localparam logic [7:0] SPT_OFF_REMAIN = 8'h10;

   // control register field positions
   localparam int SPT_CTRL_PAT_LO = 0;
   localparam int SPT_CTRL_PAT_HI = 1;
   localparam int SPT_CTRL_START  = 2;
   localparam int SPT_CTRL_HOURS  = 3;
   localparam int SPT_CTRL_EVTASG = 4;
   localparam int SPT_CTRL_ANALOG = 5;
   localparam int SPT_CTRL_RUN    = 6;

   // status register field positions
   localparam int SPT_STAT_END    = 0;
   localparam int SPT_STAT_RUN    = 1;
   localparam int SPT_STAT_INBAND = 2;
   localparam int SPT_STAT_START  = 3;

   // value ranges: soak 1..9999, band off(0) or 1..9999 raw counts
   localparam int               SPT_VAL_W     = 14;
   localparam logic [13:0]      SPT_SOAK_MIN  = 14'h0001;
   localparam logic [13:0]      SPT_SOAK_MAX  = 14'h270f;
   localparam logic [13:0]      SPT_BAND_MIN  = 14'h0001;
   localparam logic [13:0]      SPT_BAND_MAX  = 14'h270f;
   localparam logic [13:0]      SPT_BAND_OFF  = 14'h0000;
   localparam logic [13:0]      SPT_SOAK_RST  = 14'h0001;

   // time base: seconds from the clock, then 60 s per min, 60 min per h
   localparam int          SPT_CLK_HZ      = 50_000_000;
   localparam int          SPT_TICK_SEC    = 1;
   localparam int          SPT_CYC_PER_SEC = SPT_CLK_HZ * SPT_TICK_SEC;
   localparam logic [5:0]  SPT_SEC_PER_MIN = 6'h3c;
   localparam logic [5:0]  SPT_MIN_PER_HR  = 6'h3c;

   // program pattern selection
   typedef enum logic [1:0] {
      SPT_PAT_OFF  = 2'h0,
      SPT_PAT_STOP = 2'h1,
      SPT_PAT_KEEP_RUNNING_OPTION = 2'h2
   } spt_pat_t;

   // program sequencer states, one-hot
   typedef enum logic [2:0] {
      SPT_ST_IDLE = 3'h1,
      SPT_ST_SOAK = 3'h2,
      SPT_ST_DONE = 3'h4
   } spt_state_t;

endpackage

// File: src/spt_tick_if.sv
// link between the sequencer and its soak time base
`timescale 1ns/10ps
`default_nettype none
interface spt_tick_if;
   logic run;        // time base advances only while high
   logic clear;      // restart partial unit from zero
   logic unitHours;  // tick per hour instead of per minute
   logic tick;       // one-cycle pulse per elapsed unit

   modport seq (output run, output clear, output unitHours, input tick);
   modport tmr (input run, input clear, input unitHours, output tick);
endinterface
`default_nettype wire

// File: src/spt_soak_tick.sv
// pausable minute/hour time base for the soak timer
`timescale 1ns/10ps
`default_nettype none
module spt_soak_tick
   import spt_pkg::*;
#(
   parameter logic [31:0] CYC_PER_SEC = SPT_CYC_PER_SEC
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rstn,
   // sequencer side
   spt_tick_if.tmr   tb
);

   typedef struct packed {
      logic [31:0] cyc;
      logic [5:0]  sec;
      logic [5:0]  min;
      logic        tick;
   } spt_tick_st_t;

   spt_tick_st_t q, d;

   // partial units are held while paused so the count resumes, not restarts
   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (tb.clear) begin
         d.cyc = '0;
         d.sec = '0;
         d.min = '0;
      end else if (tb.run) begin
         if (q.cyc == CYC_PER_SEC - 32'h1) begin
            d.cyc = '0;
            if (q.sec == SPT_SEC_PER_MIN - 6'h1) begin
               d.sec = '0;
               if (!tb.unitHours) begin
                  d.tick = 1'b1;
                  d.min  = '0;
               end else if (q.min == SPT_MIN_PER_HR - 6'h1) begin
                  d.tick = 1'b1;
                  d.min  = '0;
               end else begin
                  d.min = q.min + 6'h1;
               end
            end else begin
               d.sec = q.sec + 6'h1;
            end
         end else begin
            d.cyc = q.cyc + 32'h1;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tb.tick = q.tick;

endmodule // spt_soak_tick
`default_nettype wire

// File: src/spt_top.sv
// soak program timer: start/reset sequencer, wait band and soak count
// notes for users
// - band check is inclusive; the analog flag names units only
// - band units: tenths of a degree or hundredths of percent
// - a preset lowered below elapsed ends the soak next edge
// - a paused time base keeps its partial unit
// - a start or reset also clears that partial unit
// - repeated start while active, or reset while idle, is ignored
// - pattern off forces idle and drops the event assignment
// - reset after expiry leaves run mode as it stands
// - each start and reset pulses nvWriteReq once; pace them
// - the CYC_PER_SEC parameter sets the second; keep it small in simulation
// - read data stand one cycle after the strobe, else zero
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module spt_top
   import spt_pkg::*;
#(
   parameter logic [31:0] CYC_PER_SEC = SPT_CYC_PER_SEC
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   // process values, same clock, signed raw counts
   input  wire logic [15:0] pvValue,
   input  wire logic [15:0] spValue,
   // start sources outside the register port
   input  wire logic        evtPin,
   input  wire logic        commStartCmd,
   input  wire logic        commResetCmd,
   // controller outputs
   output logic             runMode,
   output logic             progEndOut,
   output logic             endIndicate,
   output logic             nvWriteReq,
   output logic      [13:0] soakRemaining
);

   ////////////////////////////////////////////////////////////////////////
   // state

   // all state in one packed struct: d is built in one process and
   // registered in another, so no flop can escape the reset
   typedef struct packed {
      spt_state_t  seq;
      spt_pat_t    pattern;
      logic        unitHours;
      logic        evtAssign;
      logic        analogIn;
      logic        runMode;
      logic        endFlag;
      logic        nvWrite;
      logic [13:0] soakDur;
      logic [13:0] bandVal;
      logic [13:0] elapsed;
      logic [13:0] remain;   // registered so the output comes from a flop
      logic [31:0] rdData;
      logic [1:0]  evtSync;
   } spt_top_st_t;

   spt_top_st_t q, d;

   // time base controls travel together through one link
   spt_tick_if tickLink ();

   ////////////////////////////////////////////////////////////////////////
   // soak time base

   // pausable minute/hour base, cleared on every start and reset
   spt_soak_tick #(
      .CYC_PER_SEC (CYC_PER_SEC)
   ) u_tick (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tb       (tickLink.tmr)
   );

   ////////////////////////////////////////////////////////////////////////
   // wait band check

   // value and set point share this clock, so no sync is needed here
   logic signed [16:0] pvDiff;
   logic        [16:0] pvDist;
   logic               inBand;

   // widened by one bit so the difference of two extremes cannot wrap
   always_comb begin
      pvDiff = $signed({pvValue[15], pvValue}) - $signed({spValue[15], spValue});
      pvDist = pvDiff[16] ? 17'(-pvDiff) : 17'(pvDiff);
      // band off: treated as unbounded
      if (q.bandVal == SPT_BAND_OFF) begin
         inBand = 1'b1;
      end else begin
         inBand = (pvDist <= {3'h0, q.bandVal});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start and reset requests

   // single-cycle decodes of this cycle's inputs
   logic        ctrlWr;
   logic        soakWr;
   logic        bandWr;
   logic        patOff;
   logic        isIdle;
   logic        evtLevel;
   logic        keyStart;
   logic        keyReset;
   logic        commStart;
   logic        commReset;
   logic        evtStart;
   logic        evtReset;
   logic        doStart;
   logic        doReset;
   spt_pat_t    newPat;
   logic [13:0] wrVal;

   // decode and gather the three start sources
   always_comb begin
      ctrlWr    = regWr && (regAddr == SPT_OFF_CTRL);
      soakWr    = regWr && (regAddr == SPT_OFF_SOAK);
      bandWr    = regWr && (regAddr == SPT_OFF_BAND);
      wrVal     = regWrData[SPT_VAL_W-1:0];
      newPat    = spt_pat_t'(regWrData[SPT_CTRL_PAT_HI:SPT_CTRL_PAT_LO]);
      patOff    = (q.pattern == SPT_PAT_OFF);
      isIdle    = (q.seq == SPT_ST_IDLE);
      evtLevel  = q.evtSync[1];
      // key writes to the start field only while no event owns it
      keyStart  = ctrlWr && !q.evtAssign && regWrData[SPT_CTRL_START] && isIdle;
      keyReset  = ctrlWr && !q.evtAssign && !regWrData[SPT_CTRL_START] && !isIdle;
      commStart = commStartCmd && !q.evtAssign && isIdle;
      commReset = commResetCmd && !q.evtAssign && !isIdle;
      // event input is a level: on means start, off means reset
      evtStart  = q.evtAssign && evtLevel && isIdle;
      evtReset  = q.evtAssign && !evtLevel && !isIdle;
      // pattern off blocks every source at once
      doStart   = !patOff && (keyStart || commStart || evtStart);
      doReset   = !patOff && (keyReset || commReset || evtReset);
   end

   ////////////////////////////////////////////////////////////////////////
   // time base control

   // clear on any start or reset so a new soak never inherits seconds
   // time base runs only while soaking inside the band
   assign tickLink.run       = (q.seq == SPT_ST_SOAK) && inBand;
   assign tickLink.clear     = doStart || doReset;
   assign tickLink.unitHours = q.unitHours;

   ////////////////////////////////////////////////////////////////////////
   // next state

   // spare bit so the compare with the preset cannot wrap
   logic [14:0] nextElapsed;

   // next state: pulses default low, read data default zero
   always_comb begin
      d           = q;
      d.nvWrite   = 1'b0;
      d.rdData    = '0;
      // event pin through two flops before anything reads it
      d.evtSync   = {q.evtSync[0], evtPin};
      nextElapsed = {1'b0, q.elapsed} + {14'h0, tickLink.tick};

      // control register: pattern, unit, input kind, assignment, run key
      if (ctrlWr) begin
         d.unitHours = regWrData[SPT_CTRL_HOURS];
         d.analogIn  = regWrData[SPT_CTRL_ANALOG];
         d.runMode   = regWrData[SPT_CTRL_RUN];
         // code 3 is not a pattern; the old one stays
         if (newPat == SPT_PAT_STOP || newPat == SPT_PAT_KEEP_RUNNING_OPTION || newPat == SPT_PAT_OFF) begin
            d.pattern = newPat;
         end
         if (d.pattern == SPT_PAT_OFF) begin
            d.evtAssign = 1'b0;
            d.seq       = SPT_ST_IDLE;
            d.endFlag   = 1'b0;
            d.elapsed   = '0;
         end else begin
            d.evtAssign = regWrData[SPT_CTRL_EVTASG];
         end
      end

      // soak preset, out of range writes keep the old value
      if (soakWr && wrVal >= SPT_SOAK_MIN && wrVal <= SPT_SOAK_MAX) begin
         d.soakDur = wrVal;
      end

      // band is tenths of a degree or hundredths of percent: same raw range
      if (bandWr && (wrVal == SPT_BAND_OFF || (wrVal >= SPT_BAND_MIN && wrVal <= SPT_BAND_MAX))) begin
         d.bandVal = wrVal;
      end

      // sequencer; start, and a reset while soaking, override a run key write in the same cycle
      unique case (q.seq)
         // waiting: only a start moves on
         SPT_ST_IDLE: begin
            if (doStart) begin
               d.seq     = SPT_ST_SOAK;
               d.elapsed = '0;
               d.endFlag = 1'b0;
               d.runMode = 1'b1;
               d.nvWrite = 1'b1;
            end
         end
         // reset is checked first so an operator's reset is never lost
         SPT_ST_SOAK: begin
            if (doReset) begin
               d.seq     = SPT_ST_IDLE;
               d.elapsed = '0;
               d.runMode = 1'b0;
               d.nvWrite = 1'b1;
            end else if (nextElapsed >= {1'b0, q.soakDur}) begin
               d.seq     = SPT_ST_DONE;
               d.elapsed = q.soakDur;
               d.endFlag = 1'b1;
               // stop pattern drops control; continue leaves it running
               if (q.pattern == SPT_PAT_STOP) begin
                  d.runMode = 1'b0;
               end
            end else begin
               d.elapsed = nextElapsed[13:0];
            end
         end
         SPT_ST_DONE: begin
            // after expiry a reset leaves run mode as it is
            if (doReset) begin
               d.seq     = SPT_ST_IDLE;
               d.elapsed = '0;
               d.endFlag = 1'b0;
               d.nvWrite = 1'b1;
            end
         end
         // illegal one-hot code: fall back to idle
         default: begin
            d.seq     = SPT_ST_IDLE;
            d.elapsed = '0;
            d.endFlag = 1'b0;
         end
      endcase

      // pattern off wins over the sequencer, so nothing runs on unseen
      if (ctrlWr && d.pattern == SPT_PAT_OFF) begin
         d.seq     = SPT_ST_IDLE;
         d.endFlag = 1'b0;
         d.elapsed = '0;
      end

      // remaining time from next-state values, in step with elapsed
      d.remain = d.soakDur - d.elapsed;

      // read data valid in the cycle after the strobe only
      if (regRd) begin
         unique case (regAddr)
            // start bit reads the sequencer, not the last write
            SPT_OFF_CTRL: begin
               d.rdData[SPT_CTRL_PAT_HI:SPT_CTRL_PAT_LO] = q.pattern;
               d.rdData[SPT_CTRL_START]  = !isIdle;
               d.rdData[SPT_CTRL_HOURS]  = q.unitHours;
               d.rdData[SPT_CTRL_EVTASG] = q.evtAssign;
               d.rdData[SPT_CTRL_ANALOG] = q.analogIn;
               d.rdData[SPT_CTRL_RUN]    = q.runMode;
            end
            SPT_OFF_SOAK: begin
               d.rdData[SPT_VAL_W-1:0] = q.soakDur;
            end
            SPT_OFF_BAND: begin
               d.rdData[SPT_VAL_W-1:0] = q.bandVal;
            end
            // live band state, to watch the wait band settle
            SPT_OFF_STATUS: begin
               d.rdData[SPT_STAT_END]    = q.endFlag;
               d.rdData[SPT_STAT_RUN]    = q.runMode;
               d.rdData[SPT_STAT_INBAND] = inBand;
               d.rdData[SPT_STAT_START]  = !isIdle;
            end
            SPT_OFF_REMAIN: begin
               d.rdData[SPT_VAL_W-1:0] = q.remain;
            end
            // unmapped offsets read as zero
            default: begin
               d.rdData = '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   // synchronous reset; one assignment registers the whole struct
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         q           <= '0;
         q.seq       <= SPT_ST_IDLE;
         q.pattern   <= SPT_PAT_OFF;
         q.soakDur   <= SPT_SOAK_RST;
         q.bandVal   <= SPT_BAND_OFF;
         q.remain    <= SPT_SOAK_RST;  // preset of one, nothing elapsed
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops

   assign regRdData     = q.rdData;
   assign runMode       = q.runMode;
   // both end outputs share one flag, so they never disagree
   assign progEndOut    = q.endFlag;
   assign endIndicate   = q.endFlag;
   assign nvWriteReq    = q.nvWrite;
   assign soakRemaining = q.remain;

endmodule // spt_top
`default_nettype wire

// File: tb/spt_top_assertions.sv
// concurrent checks on the soak program timer ports
`timescale 1ns/10ps
`default_nettype none
module spt_top_assertions
   import spt_pkg::*;
#(
   parameter logic [31:0] CYC_PER_SEC = SPT_CYC_PER_SEC
) (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rstn,
   // register port
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdData,
   // process values and start sources
   input wire logic [15:0] pvValue,
   input wire logic [15:0] spValue,
   input wire logic        evtPin,
   input wire logic        commStartCmd,
   input wire logic        commResetCmd,
   // controller outputs
   input wire logic        runMode,
   input wire logic        progEndOut,
   input wire logic        endIndicate,
   input wire logic        nvWriteReq,
   input wire logic [13:0] soakRemaining
);
   logic [1:0]         patQ;
   logic [13:0]        bandQ;
   logic [3:0]         evtAgeQ;
   logic               evtLastQ;
   logic signed [16:0] diff;
   logic               outBand;

   ////////////////////////////////////////////////////////////////////////////////
   // shadow of pattern and band; refused writes leave them alone
   // event age covers the pin sync chain, so event actions are not blamed on nothing
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         patQ     <= 2'h0;
         bandQ    <= 14'h0;
         evtAgeQ  <= 4'h0;
         evtLastQ <= 1'b0;
      end else begin
         evtLastQ <= evtPin;
         evtAgeQ  <= (evtPin != evtLastQ) ? 4'h0 : ((evtAgeQ == 4'hf) ? evtAgeQ : evtAgeQ + 4'h1);
         if (regWr && regAddr == SPT_OFF_CTRL && regWrData[1:0] != 2'h3) begin
            patQ <= regWrData[1:0];
         end
         if (regWr && regAddr == SPT_OFF_BAND && regWrData[13:0] <= SPT_BAND_MAX) begin
            bandQ <= regWrData[13:0];
         end
      end
   end

   // inclusive band around the set point, signed raw counts
   assign diff    = {pvValue[15], pvValue} - {spValue[15], spValue};
   assign outBand = (bandQ != 14'h0) && (((diff < 0) ? -diff : diff) > {3'h0, bandQ});

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_endRise;
      $rose(progEndOut);
   endsequence
   sequence s_outQuiet;
      outBand && !regWr && !commStartCmd && !commResetCmd && evtAgeQ == 4'hf;
   endsequence

   property p_endMirror;
      endIndicate == progEndOut;
   endproperty
   a_endMirror: assert property (p_endMirror) else $error("end indication differs from end output");
   property p_nvCause;
      nvWriteReq |-> $past(regWr) || $past(commStartCmd) || $past(commResetCmd) || evtAgeQ < 4'h8;
   endproperty
   a_nvCause: assert property (p_nvCause) else $error("memory write without start or reset");
   property p_endRemain;
      s_endRise |-> soakRemaining == 14'h0;
   endproperty
   a_endRemain: assert property (p_endRemain) else $error("end raised with time remaining");
   property p_stopEnd;
      s_endRise ##0 (patQ == SPT_PAT_STOP) |-> ##[0:1] !runMode;
   endproperty
   a_stopEnd: assert property (p_stopEnd) else $error("stop pattern kept running at end");
   property p_contEnd;
      s_endRise ##0 (patQ == SPT_PAT_KEEP_RUNNING_OPTION && $past(runMode)) |-> runMode;
   endproperty
   a_contEnd: assert property (p_contEnd) else $error("continue pattern stopped at end");
   property p_endHold;
      progEndOut && !regWr && !commResetCmd && evtAgeQ == 4'hf |=> progEndOut;
   endproperty
   a_endHold: assert property (p_endHold) else $error("end cleared without a reset");
   property p_offIdle;
      patQ == SPT_PAT_OFF |=> !progEndOut;
   endproperty
   a_offIdle: assert property (p_offIdle) else $error("end shown with pattern off");
   property p_pause;
      s_outQuiet [*3] |-> $stable(soakRemaining);
   endproperty
   a_pause: assert property (p_pause) else $error("soak time moved outside the band");
endmodule // spt_top_assertions

bind spt_top spt_top_assertions #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (
   .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
   .regRd(regRd), .regRdData(regRdData), .pvValue(pvValue), .spValue(spValue), .evtPin(evtPin),
   .commStartCmd(commStartCmd), .commResetCmd(commResetCmd), .runMode(runMode),
   .progEndOut(progEndOut), .endIndicate(endIndicate), .nvWriteReq(nvWriteReq),
   .soakRemaining(soakRemaining));
`default_nettype wire

// File: tb/spt_host_model.sv
// operator, event input and comms host in front of the timer
`timescale 1ns/10ps
`default_nettype none
module spt_host_model #(
   parameter int MIN_GAP = 4
) (
   // clock
   input wire logic         core_clk,
   // start sources
   output var logic         evtPin,
   output var logic         commStartCmd,
   output var logic         commResetCmd,
   // process values
   output var logic [15:0]  pvValue,
   output var logic [15:0]  spValue
);
   int sinceCmd = 0;

   initial begin
      evtPin       = 1'b0;
      commStartCmd = 1'b0;
      commResetCmd = 1'b0;
      pvValue      = 16'h0;
      spValue      = 16'h0;
   end

   // spacing of start/reset requests spares the memory endurance
   always @(posedge core_clk) sinceCmd++;

   // one-cycle comms command, start or reset
   task automatic comm(input logic start);
      while (sinceCmd < MIN_GAP) @(posedge core_clk);
      @(posedge core_clk);
      commStartCmd <= start;
      commResetCmd <= !start;
      @(posedge core_clk);
      commStartCmd <= 1'b0;
      commResetCmd <= 1'b0;
      sinceCmd = 0;
   endtask

   // event level: high starts, low resets
   task automatic setEvt(input logic lvl);
      while (sinceCmd < MIN_GAP) @(posedge core_clk);
      @(posedge core_clk);
      evtPin <= lvl;
      sinceCmd = 0;
   endtask

   task automatic setSp(input logic [15:0] v);
      @(posedge core_clk);
      spValue <= v;
   endtask

   task automatic setPv(input logic [15:0] v);
      @(posedge core_clk);
      pvValue <= v;
   endtask
endmodule // spt_host_model
`default_nettype wire

// File: tb/spt_top_test.sv
// self-checking bench of the soak program timer
`timescale 1ns/10ps
`default_nettype none
module spt_top_test
   import spt_pkg::*;
;
   // four cycles a second keeps a minute at 240 cycles
   localparam logic [31:0] CPS = 32'h4;
   logic        core_clk  = 1'b0;
   logic        rstn      = 1'b0;
   logic [7:0]  regAddr;
   logic [31:0] regWrData;
   logic        regWr;
   logic        regRd;
   logic [31:0] regRdData;
   logic [15:0] pvValue, spValue;
   logic        evtPin, commStartCmd, commResetCmd;
   logic        runMode, progEndOut, endIndicate, nvWriteReq;
   logic [13:0] soakRemaining;
   int          errors = 0;
   int          checks = 0;
   int          cycles = 0;
   int          n;

   spt_top #(.CYC_PER_SEC(CPS)) uut (
      .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .pvValue(pvValue), .spValue(spValue), .evtPin(evtPin),
      .commStartCmd(commStartCmd), .commResetCmd(commResetCmd), .runMode(runMode),
      .progEndOut(progEndOut), .endIndicate(endIndicate), .nvWriteReq(nvWriteReq),
      .soakRemaining(soakRemaining));
   spt_host_model #(.MIN_GAP(4)) host (
      .core_clk(core_clk), .evtPin(evtPin), .commStartCmd(commStartCmd),
      .commResetCmd(commResetCmd), .pvValue(pvValue), .spValue(spValue));

   always #10 core_clk = ~core_clk;

   // hang guard, well above the roughly 1350 cycles the tests need
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bit1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // one-cycle strobes; settle past the edge before anyone looks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffff_ffff);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 chk(regRdData & m, exp);
   endtask

   // cycles until the end output reaches a level, bounded
   task automatic waitEnd(input logic lvl, output int cnt);
      cnt = 0;
      while (progEndOut !== lvl && cnt < 2000) begin
         @(posedge core_clk);
         #1 cnt++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      regAddr   <= 8'h0;
      regWrData <= 32'h0;
      regWr     <= 1'b0;
      regRd     <= 1'b0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      // reset values and refused writes
      rd(SPT_OFF_CTRL, 32'h0);
      rd(SPT_OFF_BAND, 32'h0);
      rd(SPT_OFF_REMAIN, 32'h1);
      rd(8'h14, 32'h0);
      wr(SPT_OFF_SOAK, 32'h0);
      rd(SPT_OFF_SOAK, 32'h1);
      wr(SPT_OFF_BAND, 32'h2710);
      rd(SPT_OFF_BAND, 32'h0);
      wr(SPT_OFF_BAND, 32'h270f);
      rd(SPT_OFF_BAND, 32'h270f);
      wr(SPT_OFF_CTRL, 32'h3);
      rd(SPT_OFF_CTRL, 32'h0);
      wr(SPT_OFF_CTRL, 32'h4);
      bit1(nvWriteReq, 1'b0);
      // stop pattern, one minute, band of ten; leave the band midway
      wr(SPT_OFF_BAND, 32'ha);
      wr(SPT_OFF_CTRL, 32'h1);
      wr(SPT_OFF_CTRL, 32'h5);
      bit1(runMode, 1'b1);
      bit1(nvWriteReq, 1'b1);
      repeat (120) @(posedge core_clk);
      host.setPv(16'h14);
      repeat (300) @(posedge core_clk);
      #1 bit1(progEndOut, 1'b0);
      host.setPv(16'hfff6); // -10 sits on the inclusive edge
      waitEnd(1'b1, n);
      bit1(n > 100 && n < 140, 1'b1);
      rd(SPT_OFF_REMAIN, 32'h0);
      bit1(runMode, 1'b0);
      bit1(endIndicate, 1'b1);
      wr(SPT_OFF_CTRL, 32'h1);
      bit1(progEndOut, 1'b0);
      bit1(nvWriteReq, 1'b1);
      rd(SPT_OFF_REMAIN, 32'h1);
      // reset before expiry, then a fresh full minute
      wr(SPT_OFF_CTRL, 32'h5);
      repeat (200) @(posedge core_clk);
      wr(SPT_OFF_CTRL, 32'h41);
      bit1(runMode, 1'b0);
      wr(SPT_OFF_CTRL, 32'h5);
      waitEnd(1'b1, n);
      bit1(n > 220 && n < 260, 1'b1);
      wr(SPT_OFF_CTRL, 32'h1);
      // continue pattern, band off, value far away, started over comms
      wr(SPT_OFF_BAND, 32'h0);
      wr(SPT_OFF_CTRL, 32'h2);
      host.setPv(16'h7000);
      host.comm(1'b1);
      waitEnd(1'b1, n);
      bit1(n > 220 && n < 260, 1'b1);
      bit1(runMode, 1'b1);
      host.comm(1'b0);
      waitEnd(1'b0, n);
      bit1(n < 4, 1'b1);
      // event owns the start: comms and keys are refused
      wr(SPT_OFF_CTRL, 32'h11);
      host.comm(1'b1);
      rd(SPT_OFF_STATUS, 32'h0, 32'h8);
      host.setEvt(1'b1);
      repeat (6) @(posedge core_clk);
      rd(SPT_OFF_STATUS, 32'h8, 32'h8);
      rd(SPT_OFF_CTRL, 32'h4, 32'h4);
      wr(SPT_OFF_CTRL, 32'h51);
      rd(SPT_OFF_STATUS, 32'h8, 32'h8);
      host.setEvt(1'b0);
      repeat (6) @(posedge core_clk);
      rd(SPT_OFF_STATUS, 32'h0, 32'h8);
      bit1(runMode, 1'b0);
      wr(SPT_OFF_CTRL, 32'h10);
      rd(SPT_OFF_CTRL, 32'h0, 32'h10);
      // band around a moved set point; distance ten is still inside
      wr(SPT_OFF_BAND, 32'ha);
      host.setSp(16'h700a);
      rd(SPT_OFF_STATUS, 32'h4, 32'h4);
      host.setSp(16'h700b);
      rd(SPT_OFF_STATUS, 32'h0, 32'h4);
      print_verdict();
   end
endmodule // spt_top_test
`default_nettype wire
